// [hdl/speech_frame_field_parser.sv]
// Contract
// - A 640-bit frame is the 32 kbps rate; bit 0 picks the core family.
// - Linear-prediction frames carry bandwidth and coder type as one index.
// - Transform frames: next bit picks high-quality or excitation core.
// - Excitation core: two following bits give its coder type.
// - High-quality core: prev-core bit, rate bit only if prev was LP.
// - 32 kbps LP frames: extension flag, time 55 bits or freq 31 bits.
// - 48 kbps uses excitation core; wide content adds gap filling.
// - A 1280-bit frame is 64 kbps: LP or high-quality core only.
// - Silence descriptors are 48 bits, of two kinds.
// - Descriptor bit 0 selects spectral or predictive comfort noise.
// - Spectral descriptor: 2-bit bandwidth, rate, 7-bit gain, 37-bit energy.
// - Predictive descriptor: 1-bit bandwidth and 1-bit core rate.
// - Then 3-bit hangover count, 29 pair bits, 7 low-band energy bits.
// - Wideband ends with 6 envelope bits; super-wideband 4 energy, 2 unused.
// - A 264-bit frame is channel-aware; first 5 bits are joint signalling.
// - Redundancy flag zero: treated as an ordinary 13.2 kbps frame.
// - Last three bits give the partial-copy type, eight values.
// - Two bits before that give the partial-copy offset 2/3, 5 or 7.
// - Partial and primary copies may each be of either core kind.
`timescale 1ns/1ps
`default_nettype none
`include "frame_parser_cfg.svh"

module speech_frame_field_parser (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    bit_valid_i,
    input  wire logic                    bit_i,
    input  wire logic                    bit_last_i,
    output logic                         bit_ready_o,
    input  wire logic                    field_ready_i,
    output logic                         field_valid_o,
    output frame_parser_pkg::kind_t      frame_kind_o,
    output frame_parser_pkg::core_t      core_o,
    output logic                  [4:0]  joint_index_o,
    output logic                  [2:0]  coder_type_o,
    output logic                         prev_lp_o,
    output logic                         rate16_o,
    output logic                         ext_fd_o,
    output logic                  [5:0]  ext_bits_o,
    output logic                         gap_fill_o,
    output logic                         cn_spectral_o,
    output logic                  [1:0]  cn_bandwidth_o,
    output logic                         cn_rate_o,
    output logic                  [6:0]  cn_gain_o,
    output logic                  [2:0]  cn_hangover_o,
    output logic                  [5:0]  cn_tail_o,
    output logic                  [36:0] cn_spectrum_o,
    output logic                         partial_o,
    output logic                  [2:0]  partial_offset_o,
    output frame_parser_pkg::part_t      partial_type_o,
    output logic                         partial_transform_o,
    output logic                         len_error_o
);
    import frame_parser_pkg::*;

    localparam int RW = $bits(result_t);

    typedef struct packed {
        state_t st;
    } ctl_t;

    ctl_t        cur;
    ctl_t        next_cur;
    logic        take;
    logic        push;
    logic        buf_ready;
    logic [11:0] count;
    logic [47:0] h;
    logic [4:0]  tail;
    result_t     res;
    result_t     out_res;
    logic [RW-1:0] buf_out;

    // Bits are taken only while collecting, so a full buffer stalls the source
    assign bit_ready_o = (cur.st == st_collect);
    assign take        = bit_valid_i && bit_ready_o;
    assign push        = (cur.st == st_emit) && buf_ready;

    frame_bit_capture u_capture (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .take_i  (take),
        .bit_i   (bit_i),
        .clear_i (push),
        .count_o (count),
        .head_o  (h),
        .tail_o  (tail)
    );

    // Frame-end sequencing: collect, then hold until the buffer takes it
    always_comb begin
        next_cur = cur;
        case (cur.st)
            st_collect: begin
                if (take && bit_last_i) begin
                    next_cur.st = st_emit;
                end
            end
            st_emit: begin
                if (buf_ready) begin
                    next_cur.st = st_collect;
                end
            end
            default: next_cur.st = st_collect;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '{st: st_collect};
        end else begin
            cur <= next_cur;
        end
    end

    // Field decode from the captured head and tail; length picks the layout
    always_comb begin
        res           = '0;
        res.kind      = kind_none;
        res.core      = core_none;
        res.part_type = partial_type_empty;
        if (count == `LEN_32 || count == `LEN_64) begin
            res.kind = (count == `LEN_32) ? kind_32 : kind_64;
            if (!h[`HEAD_TOP-`P_CORE]) begin
                res.core  = core_lp;
                res.joint = {1'b0, h[`HEAD_TOP-`P_JOINT -: `W_JOINT]};
                if (count == `LEN_32) begin
                    // Flag is reported even when no extension is coded
                    res.ext_fd   = h[`HEAD_TOP-`P_EXTFLAG];
                    res.ext_bits = res.ext_fd ? `EXT_FD_BITS
                                              : `EXT_TD_BITS;
                end
            end else if (count == `LEN_64) begin
                // No excitation core at this rate, so no selector bit
                res.core    = core_hq;
                res.prev_lp = h[`HEAD_TOP-`P64_PREVLP];
                res.rate16  = res.prev_lp && h[`HEAD_TOP-`P64_RATE];
            end else if (h[`HEAD_TOP-`P_SEL]) begin
                res.core    = core_hq;
                res.prev_lp = h[`HEAD_TOP-`P32_PREVLP];
                res.rate16  = res.prev_lp && h[`HEAD_TOP-`P32_RATE];
            end else begin
                res.core       = core_exc;
                res.coder_type = {1'b0,
                    h[`HEAD_TOP-`P_EXC_CT -: `W_EXC_CT]};
            end
        end else if (count == `LEN_48 || count == `LEN_96
                     || count == `LEN_128) begin
            if (count == `LEN_48) begin
                res.kind = kind_48;
            end else if (count == `LEN_96) begin
                res.kind = kind_96;
            end else begin
                res.kind = kind_128;
            end
            res.core       = core_exc;
            res.joint      = {3'h0, h[`HEAD_TOP-`P_HR_BW -: 2]};
            // Bandwidth codes 2 and 3 are super-wideband and fullband
            res.gap_fill   = h[`HEAD_TOP-`P_HR_BW];
            res.coder_type = h[`HEAD_TOP-`P_HR_CT -: `W_HR_CT];
        end else if (count == `LEN_SID) begin
            res.kind        = kind_sid;
            res.cn_spectral = !h[`HEAD_TOP-`P_CN_TYPE];
            if (res.cn_spectral) begin
                res.cn_bw       = h[`HEAD_TOP-`P_FD_BW -: 2];
                res.cn_rate     = h[`HEAD_TOP-`P_FD_RATE];
                res.cn_gain     = h[`HEAD_TOP-`P_FD_GAIN -: `W_GAIN];
                res.cn_spectrum = h[`HEAD_TOP-`P_FD_ENER -: `W_FD_ENER];
            end else begin
                res.cn_bw   = {1'b0, h[`HEAD_TOP-`P_LP_BW]};
                res.cn_rate = h[`HEAD_TOP-`P_LP_RATE];
                res.cn_hang = h[`HEAD_TOP-`P_LP_HANG -: `W_LP_HANG];
                res.cn_spectrum = {8'h00,
                    h[`HEAD_TOP-`P_LP_LSF -: `W_LP_LSF]};
                res.cn_gain = h[`HEAD_TOP-`P_LP_ENER -: `W_GAIN];
                // Super-wideband drops the two unused trailing bits
                if (res.cn_bw[0]) begin
                    res.cn_tail = {2'h0,
                        h[`HEAD_TOP-`P_LP_ENV -: `W_LP_HB]};
                end else begin
                    res.cn_tail = h[`HEAD_TOP-`P_LP_ENV -: `W_LP_ENV];
                end
            end
        end else if (count == `LEN_CA) begin
            res.kind    = kind_ca;
            res.joint   = h[`HEAD_TOP-`P_CA_SIG -: `W_CA_SIG];
            res.partial = h[`HEAD_TOP-`P_CA_RF];
            // With no redundancy the tail is ordinary payload, not fields
            if (res.partial) begin
                case (tail[4:3])
                    2'h0:    res.part_off = `OFFSET_A;
                    2'h1:    res.part_off = `OFFSET_B;
                    2'h2:    res.part_off = `OFFSET_C;
                    default: res.part_off = `OFFSET_D;
                endcase
                res.part_type = part_t'(tail[2:0]);
                // Either partial kind may ride with either primary kind
                res.part_transform =
                    (tail[2:0] != 3'h0) && (tail[2:0] < 3'h4);
            end
        end else begin
            res.len_error = 1'b1;
        end
    end

    frame_field_buffer #(
        .WIDTH (RW)
    ) u_buffer (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (cur.st == st_emit),
        .in_data_i   (res),
        .in_ready_o  (buf_ready),
        .out_valid_o (field_valid_o),
        .out_data_o  (buf_out),
        .out_ready_i (field_ready_i)
    );

    // Field ports are slices of the buffer head entry
    assign out_res             = result_t'(buf_out);
    assign frame_kind_o        = out_res.kind;
    assign core_o              = out_res.core;
    assign joint_index_o       = out_res.joint;
    assign coder_type_o        = out_res.coder_type;
    assign prev_lp_o           = out_res.prev_lp;
    assign rate16_o            = out_res.rate16;
    assign ext_fd_o            = out_res.ext_fd;
    assign ext_bits_o          = out_res.ext_bits;
    assign gap_fill_o          = out_res.gap_fill;
    assign cn_spectral_o       = out_res.cn_spectral;
    assign cn_bandwidth_o      = out_res.cn_bw;
    assign cn_rate_o           = out_res.cn_rate;
    assign cn_gain_o           = out_res.cn_gain;
    assign cn_hangover_o       = out_res.cn_hang;
    assign cn_tail_o           = out_res.cn_tail;
    assign cn_spectrum_o       = out_res.cn_spectrum;
    assign partial_o           = out_res.partial;
    assign partial_offset_o    = out_res.part_off;
    assign partial_type_o      = out_res.part_type;
    assign partial_transform_o = out_res.part_transform;
    assign len_error_o         = out_res.len_error;

    // Checks on the decoded record as it enters the buffer
    property p_len_32;
        @(posedge clk_i) disable iff (rst_i)
        push && count == `LEN_32 |-> res.kind == kind_32
            && (res.core == core_lp) == !h[47];
    endproperty
    a_len_32: assert property (p_len_32)
        else $error("640-bit frame misclassified");

    property p_joint;
        @(posedge clk_i) disable iff (rst_i)
        push && res.core == core_lp |-> res.joint == {1'b0, h[46:43]};
    endproperty
    a_joint: assert property (p_joint)
        else $error("joint index not taken from bits 1 to 4");

    property p_sel;
        @(posedge clk_i) disable iff (rst_i)
        push && res.kind == kind_32 && h[47]
            |-> res.core == (h[46] ? core_hq : core_exc);
    endproperty
    a_sel: assert property (p_sel)
        else $error("transform core selector wrong");

    property p_exc_ct;
        @(posedge clk_i) disable iff (rst_i)
        push && res.kind == kind_32 && res.core == core_exc
            |-> res.coder_type == {1'b0, h[45:44]};
    endproperty
    a_exc_ct: assert property (p_exc_ct)
        else $error("excitation coder type wrong");

    property p_switch;
        @(posedge clk_i) disable iff (rst_i)
        push && res.core == core_hq && !res.prev_lp |-> !res.rate16;
    endproperty
    a_switch: assert property (p_switch)
        else $error("rate bit used without previous LP frame");

    property p_ext;
        @(posedge clk_i) disable iff (rst_i)
        push && res.kind == kind_32 && res.core == core_lp
            |-> res.ext_bits == (h[42] ? 6'h1F : 6'h37);
    endproperty
    a_ext: assert property (p_ext)
        else $error("extension bit count wrong");

    property p_48;
        @(posedge clk_i) disable iff (rst_i)
        push && count == `LEN_48 |-> res.core == core_exc
            && res.gap_fill == h[47];
    endproperty
    a_48: assert property (p_48)
        else $error("48 kbps frame not excitation core");

    property p_64;
        @(posedge clk_i) disable iff (rst_i)
        push && count == `LEN_64 |-> res.kind == kind_64
            && res.core != core_exc;
    endproperty
    a_64: assert property (p_64)
        else $error("1280-bit frame misclassified");

    property p_sid;
        @(posedge clk_i) disable iff (rst_i)
        push && count == `LEN_SID |-> res.kind == kind_sid
            && res.cn_spectral == !h[47];
    endproperty
    a_sid: assert property (p_sid)
        else $error("descriptor type flag wrong");

    property p_ca_tail;
        @(posedge clk_i) disable iff (rst_i)
        push && count == `LEN_CA && h[43]
            |-> res.part_type == part_t'(tail[2:0]);
    endproperty
    a_ca_tail: assert property (p_ca_tail)
        else $error("partial type not from last three bits");

    property p_bad_len;
        @(posedge clk_i) disable iff (rst_i)
        push && res.len_error |-> res.core == core_none
            && res.kind == kind_none && !res.partial;
    endproperty
    a_bad_len: assert property (p_bad_len)
        else $error("bad-length frame left fields set");

    property p_stall;
        @(posedge clk_i) disable iff (rst_i)
        take && bit_last_i |=> !bit_ready_o;
    endproperty
    a_stall: assert property (p_stall)
        else $error("bits accepted before frame was emitted");

    c_sid: cover property (@(posedge clk_i) push && res.kind == kind_sid);
    c_ca:  cover property (@(posedge clk_i) push && res.partial);
    c_err: cover property (@(posedge clk_i) push && res.len_error);
    c_full: cover property (@(posedge clk_i)
        cur.st == st_emit && !buf_ready);
endmodule
`default_nettype wire

// [hdl/frame_parser_cfg.svh]
`ifndef FRAME_PARSER_CFG_SVH
`define FRAME_PARSER_CFG_SVH

// Frame lengths in bits, one per accepted frame size
`define LEN_SID      12'h030
`define LEN_CA       12'h108
`define LEN_32       12'h280
`define LEN_48       12'h3C0
`define LEN_64       12'h500
`define LEN_96       12'h780
`define LEN_128      12'hA00
`define COUNT_MAX    12'hFFF

// Capture windows: leading bits kept and trailing bits kept
`define HEAD_BITS    48
`define HEAD_TOP     47
`define TAIL_BITS    5

// Primary frame positions (frame bit index, first bit is 0)
`define P_CORE       0
`define P_JOINT      1
`define W_JOINT      4
`define P_EXTFLAG    5
`define P_SEL        1
`define P_EXC_CT     2
`define W_EXC_CT     2
`define P32_PREVLP   2
`define P32_RATE     3
`define P64_PREVLP   1
`define P64_RATE     2
`define EXT_TD_BITS  6'h37
`define EXT_FD_BITS  6'h1F

// High-rate excitation frame positions
`define P_HR_BW      0
`define P_HR_CT      3
`define W_HR_CT      3

// Silence descriptor positions
`define P_CN_TYPE    0
`define P_FD_BW      1
`define P_FD_RATE    3
`define P_FD_GAIN    4
`define W_GAIN       7
`define P_FD_ENER    11
`define W_FD_ENER    37
`define P_LP_BW      1
`define P_LP_RATE    2
`define P_LP_HANG    3
`define W_LP_HANG    3
`define P_LP_LSF     6
`define W_LP_LSF     29
`define P_LP_ENER    35
`define P_LP_ENV     42
`define W_LP_ENV     6
`define W_LP_HB      4

// Channel-aware joint signalling and partial-copy offsets
`define P_CA_SIG     0
`define W_CA_SIG     5
`define P_CA_RF      4
`define OFFSET_A     3'h2
`define OFFSET_B     3'h3
`define OFFSET_C     3'h5
`define OFFSET_D     3'h7

`endif

// [hdl/frame_parser_pkg.sv]
package frame_parser_pkg;

    typedef enum logic [2:0] {
        kind_none = 3'h0,
        kind_sid  = 3'h1,
        kind_ca   = 3'h2,
        kind_32   = 3'h3,
        kind_48   = 3'h4,
        kind_64   = 3'h5,
        kind_96   = 3'h6,
        kind_128  = 3'h7
    } kind_t;

    typedef enum logic [1:0] {
        core_none = 2'h0,
        core_lp   = 2'h1,
        core_hq   = 2'h2,
        core_exc  = 2'h3
    } core_t;

    typedef enum logic [2:0] {
        partial_type_empty              = 3'h0,
        partial_type_transform_freq     = 3'h1,
        partial_type_transform_time_a   = 3'h2,
        partial_type_transform_time_b   = 3'h3,
        partial_type_all_predictive     = 3'h4,
        partial_type_non_predictive     = 3'h5,
        partial_type_generic_predictive = 3'h6,
        partial_type_noise_excited      = 3'h7
    } part_t;

    typedef enum logic [0:0] {
        st_collect = 1'b0,
        st_emit    = 1'b1
    } state_t;

    typedef struct packed {
        kind_t       kind;
        core_t       core;
        logic [4:0]  joint;
        logic [2:0]  coder_type;
        logic        prev_lp;
        logic        rate16;
        logic        ext_fd;
        logic [5:0]  ext_bits;
        logic        gap_fill;
        logic        cn_spectral;
        logic [1:0]  cn_bw;
        logic        cn_rate;
        logic [6:0]  cn_gain;
        logic [2:0]  cn_hang;
        logic [5:0]  cn_tail;
        logic [36:0] cn_spectrum;
        logic        partial;
        logic [2:0]  part_off;
        part_t       part_type;
        logic        part_transform;
        logic        len_error;
    } result_t;

endpackage

// [hdl/frame_bit_capture.sv]
`timescale 1ns/1ps
`default_nettype none
`include "frame_parser_cfg.svh"

module frame_bit_capture (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        take_i,
    input  wire logic        bit_i,
    input  wire logic        clear_i,
    output logic      [11:0] count_o,
    output logic      [47:0] head_o,
    output logic      [4:0]  tail_o
);
    typedef struct packed {
        logic [11:0] count;
        logic [47:0] head;
        logic [4:0]  tail;
    } cap_t;

    cap_t cur;
    cap_t next_cur;

    // Keep the leading bits and the last few; the middle is not stored
    always_comb begin
        next_cur = cur;
        if (clear_i) begin
            next_cur = '0;
        end else if (take_i) begin
            if (cur.count < 12'(`HEAD_BITS)) begin
                next_cur.head = {cur.head[46:0], bit_i};
            end
            next_cur.tail = {cur.tail[3:0], bit_i};
            // Saturate so an oversized frame never wraps onto a good size
            if (cur.count != `COUNT_MAX) begin
                next_cur.count = cur.count + 12'h001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign count_o = cur.count;
    assign head_o  = cur.head;
    assign tail_o  = cur.tail;
endmodule
`default_nettype wire

// [hdl/frame_field_buffer.sv]
`timescale 1ns/1ps
`default_nettype none

module frame_field_buffer #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    typedef struct packed {
        logic [1:0]       cnt;
        logic [WIDTH-1:0] e0;
        logic [WIDTH-1:0] e1;
    } buf_t;

    buf_t cur;
    buf_t next_cur;
    logic push;
    logic pop;
    logic [1:0] cnt_left;

    assign in_ready_o  = (cur.cnt != 2'h2);
    assign out_valid_o = (cur.cnt != 2'h0);
    assign out_data_o  = cur.e0;
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;

    // Head entry always drives the output, so data comes from a flop
    always_comb begin
        next_cur = cur;
        cnt_left = cur.cnt - {1'b0, pop};
        if (pop) begin
            next_cur.e0 = cur.e1;
        end
        if (push) begin
            if (cnt_left == 2'h0) begin
                next_cur.e0 = in_data_i;
            end else begin
                next_cur.e1 = in_data_i;
            end
        end
        next_cur.cnt = cnt_left + {1'b0, push};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    property p_full_holds;
        @(posedge clk_i) disable iff (rst_i)
        (cur.cnt == 2'h2) && !out_ready_i |=> !in_ready_o;
    endproperty
    a_full_holds: assert property (p_full_holds)
        else $error("buffer took a word while full");
endmodule
`default_nettype wire

// [test/frame_bit_source.sv]
`timescale 1ns/1ps
`default_nettype none

// Serial frame source standing in for the encoder side
module frame_bit_source (
    input  wire logic clk_i,
    input  wire logic bit_ready_i,
    output logic      bit_valid_o,
    output logic      bit_o,
    output logic      bit_last_o
);
    initial begin
        bit_valid_o = 1'b0;
        bit_o       = 1'b0;
        bit_last_o  = 1'b0;
    end

    // One frame; slow mode idles a cycle before every bit
    task automatic send(input int len, input logic [47:0] head,
                        input logic [4:0] tail, input bit slow);
        for (int i = 0; i < len; i++) begin
            @(negedge clk_i);
            if (slow) begin
                // Idle line toggles so a stale bit never looks valid
                bit_valid_o = 1'b0;
                bit_o = ~bit_o;
                @(negedge clk_i);
            end
            bit_valid_o = 1'b1;
            bit_o = (i < 48) ? head[i] :
                    (i >= len - 5) ? tail[i - len + 5] : i[0];
            bit_last_o = (i == len - 1);
            // Hold the bit until an edge samples ready high
            @(posedge clk_i);
            while (bit_ready_i !== 1'b1) @(posedge clk_i);
        end
        @(negedge clk_i);
        bit_valid_o = 1'b0;
        bit_last_o = 1'b0;
        bit_o = ~bit_o;
    endtask
endmodule
`default_nettype wire

// [test/speech_frame_field_parser_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module speech_frame_field_parser_tb;
    import frame_parser_pkg::*;
    logic        clk_i, rst_i, field_ready_i, bit_valid_i, bit_i, bit_last_i;
    logic        bit_ready_o, field_valid_o, prev_lp_o, rate16_o, ext_fd_o;
    logic        gap_fill_o, cn_spectral_o, cn_rate_o, partial_o;
    logic        partial_transform_o, len_error_o;
    logic [1:0]  cn_bandwidth_o;
    logic [2:0]  coder_type_o, cn_hangover_o, partial_offset_o;
    logic [4:0]  joint_index_o;
    logic [5:0]  ext_bits_o, cn_tail_o;
    logic [6:0]  cn_gain_o;
    logic [36:0] cn_spectrum_o;
    kind_t       frame_kind_o;
    core_t       core_o;
    part_t       partial_type_o;
    int          fail_count, checks_done;

    speech_frame_field_parser dut (.clk_i, .rst_i, .bit_valid_i, .bit_i,
        .bit_last_i, .bit_ready_o, .field_ready_i, .field_valid_o,
        .frame_kind_o, .core_o, .joint_index_o, .coder_type_o, .prev_lp_o,
        .rate16_o, .ext_fd_o, .ext_bits_o, .gap_fill_o, .cn_spectral_o,
        .cn_bandwidth_o, .cn_rate_o, .cn_gain_o, .cn_hangover_o, .cn_tail_o,
        .cn_spectrum_o, .partial_o, .partial_offset_o, .partial_type_o,
        .partial_transform_o, .len_error_o);
    frame_bit_source src (.clk_i, .bit_ready_i(bit_ready_o),
        .bit_valid_o(bit_valid_i), .bit_o(bit_i), .bit_last_o(bit_last_i));

    // 200 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Bounded wait so a lost record shows up as a mismatch
    task automatic wait_rec;
        int n;
        n = 0;
        while (field_valid_o !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        chk(field_valid_o, 1'b1);
    endtask

    task automatic pop;
        field_ready_i = 1'b1;
        @(negedge clk_i);
        field_ready_i = 1'b0;
    endtask

    // Drops the last record, sends a frame and waits for its record
    task automatic frame(input int len, input logic [47:0] head,
                         input logic [4:0] tail, input bit slow);
        if (field_valid_o === 1'b1) pop;
        src.send(len, head, tail, slow);
        wait_rec;
    endtask

    // Multi-bit values are palindromes where bit order is left open
    initial begin
        logic [4:0] t;
        logic [2:0] offs [4];
        kind_t      ks [3];
        offs = '{3'h2, 3'h3, 3'h5, 3'h7};
        ks = '{kind_sid, kind_ca, kind_32};
        rst_i = 1'b1;
        field_ready_i = 1'b0;
        fail_count = 0;
        checks_done = 0;
        repeat (6) @(negedge clk_i);
        rst_i = 1'b0;
        frame(640, 48'h32, 5'h0, 0);
        chk({frame_kind_o, core_o, joint_index_o},
            {kind_32, core_lp, 5'h09});
        chk({ext_fd_o, ext_bits_o}, {1'b1, 6'h1F});
        frame(640, 48'h12, 5'h0, 1);
        chk({ext_fd_o, ext_bits_o}, {1'b0, 6'h37});
        frame(640, 48'h0D, 5'h0, 0);
        chk({core_o, coder_type_o}, {core_exc, 3'h3});
        frame(640, 48'h0F, 5'h0, 0);
        chk({core_o, prev_lp_o, rate16_o}, {core_hq, 2'b11});
        frame(640, 48'h0B, 5'h0, 0);
        chk({core_o, prev_lp_o, rate16_o}, {core_hq, 2'b00});
        frame(1280, 48'h03, 5'h0, 0);
        chk({frame_kind_o, core_o, prev_lp_o, rate16_o},
            {kind_64, core_hq, 2'b10});
        frame(1280, 48'h12, 5'h0, 0);
        chk({core_o, joint_index_o}, {core_lp, 5'h09});
        frame(960, 48'h3B, 5'h0, 0);
        chk({frame_kind_o, core_o, gap_fill_o, coder_type_o},
            {kind_48, core_exc, 1'b1, 3'h7});
        frame(960, 48'h38, 5'h0, 0);
        chk(gap_fill_o, 1'b0);
        // The two top rates are listed sizes, so no error and full decode
        frame(1920, 48'h2B, 5'h0, 0);
        chk({frame_kind_o, len_error_o, gap_fill_o, joint_index_o,
            coder_type_o}, {kind_96, 2'b01, 5'h03, 3'h5});
        frame(2560, 48'h0, 5'h0, 0);
        chk({frame_kind_o, core_o, len_error_o},
            {kind_128, core_exc, 1'b0});
        frame(48, 48'hFFFF_FFFF_FC1E, 5'h0, 0);
        chk({frame_kind_o, cn_spectral_o, cn_bandwidth_o, cn_rate_o},
            {kind_sid, 4'hF});
        chk({cn_gain_o, cn_spectrum_o}, {7'h41, 37'h1F_FFFF_FFFF});
        frame(48, 48'h8608_0000_002D, 5'h0, 0);
        chk({cn_spectral_o, cn_bandwidth_o, cn_rate_o, cn_hangover_o},
            {4'h1, 3'h5});
        chk({cn_gain_o, cn_tail_o, cn_spectrum_o},
            {7'h41, 6'h21, 37'h0});
        frame(48, 48'h2400_0000_0007, 5'h0, 0);
        chk({cn_bandwidth_o, cn_rate_o, cn_tail_o},
            {2'h1, 1'b1, 6'h09});
        for (int k = 0; k < 8; k++) begin
            t = {<<{k[1:0], k[2:0]}};
            frame(264, 48'h11, t, k[0]);
            chk({frame_kind_o, joint_index_o, partial_o},
                {kind_ca, 5'h11, 1'b1});
            chk({partial_offset_o, partial_type_o},
                {offs[k % 4], k[2:0]});
            chk(partial_transform_o, k >= 1 && k <= 3);
        end
        frame(264, 48'h01, 5'h1F, 0);
        chk({partial_o, partial_offset_o, partial_type_o}, 7'h0);
        frame(100, 48'hFFFF, 5'h1F, 0);
        chk({len_error_o, frame_kind_o, core_o, joint_index_o},
            {1'b1, 10'h0});
        // Consumer stalls: two records fill the buffer, the third waits
        pop;
        src.send(48, 48'h0, 5'h0, 0);
        src.send(264, 48'h0, 5'h0, 1);
        src.send(640, 48'h0, 5'h0, 0);
        repeat (3) @(negedge clk_i);
        chk(bit_ready_o, 1'b0);
        for (int j = 0; j < 3; j++) begin
            wait_rec;
            chk(frame_kind_o, ks[j]);
            pop;
        end
        test_done;
    end

    // Whole run is near 18000 cycles; allow over three times that
    initial begin
        #300000;
        fail_count++;
        test_done;
    end
endmodule
`default_nettype wire
